// >>> verif/tcap_attach_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tcap_attach_ctrl_asserts #(parameter NUM_PORTS = 3)
(
   // Inputs
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ext_mux_select,
   input wire logic mux_mode_select,
   input wire logic attach_polarity_select,
   input wire logic [NUM_PORTS-1:0] attach_in,
   input wire logic [NUM_PORTS-1:0] plug_orientation_in,
   input wire logic [NUM_PORTS-1:0] lane_a_attach_in,
   input wire logic [NUM_PORTS-1:0] lane_b_attach_in,
   // Outputs
   input wire logic [NUM_PORTS-1:0] phy_clk_en,
   input wire logic [NUM_PORTS-1:0] phy_a_en,
   input wire logic [NUM_PORTS-1:0] phy_b_en,
   input wire logic [1:0] cfg_mode
);
   // Edges since reset, saturating
   logic [1:0] up;
   always_ff @(posedge core_clk) up <= rst ? 2'h0 : up + {1'b0, ~&up};
   wire k = &up;
   wire h = attach_polarity_select & !ext_mux_select;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_cfg; k |->
      cfg_mode == $past(ext_mux_select ? 2'h0 : {mux_mode_select, !mux_mode_select}, 3); endproperty
   a_cfg: assert property (p_cfg) else $error("cfg");
   property p_m1; k && $past(!ext_mux_select && !mux_mode_select, 3) |-> cfg_mode == 2'h1; endproperty
   a_m1: assert property (p_m1) else $error("m1");
   property p_ext; k && $past(ext_mux_select & attach_polarity_select, 3) |->
      phy_clk_en == $past(attach_in, 3); endproperty
   a_ext: assert property (p_ext) else $error("ext");
   property p_ori; k && $past(h & !mux_mode_select, 3) |->
      phy_b_en == $past(attach_in & plug_orientation_in, 3); endproperty
   a_ori: assert property (p_ori) else $error("ori");
   property p_lane; k && $past(h & mux_mode_select, 3) |->
      phy_a_en == $past(lane_a_attach_in & ~lane_b_attach_in, 3); endproperty
   a_lane: assert property (p_lane) else $error("lane");
   property p_one; (phy_a_en & phy_b_en | (phy_a_en | phy_b_en) & ~phy_clk_en) == 0; endproperty
   a_one: assert property (p_one) else $error("one");
   property p_pol; k && $past(!attach_polarity_select & ext_mux_select & &attach_in, 3) |->
      phy_clk_en == 0; endproperty
   a_pol: assert property (p_pol) else $error("pol");
   property p_rst; disable iff (1'b0) rst |=> phy_clk_en == 0 && cfg_mode == 2'h1; endproperty
   a_rst: assert property (p_rst) else $error("rst");
   c_m2: cover property (cfg_mode == 2'h2 && phy_b_en != 0);
   c_m1: cover property (cfg_mode == 2'h1 && phy_a_en != 0);
   c_ext: cover property (cfg_mode == 2'h0 && phy_clk_en != 0);
endmodule // tcap_attach_ctrl_asserts
bind tcap_attach_ctrl tcap_attach_ctrl_asserts #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);
`default_nettype wire

// >>> verif/tcap_attach_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tcap_attach_ctrl_tb;
   logic core_clk = 0, rst = 1, ext_mux_select, mux_mode_select, attach_polarity_select;
   logic [2:0] att, ori, bad, attach_in, plug_orientation_in, lane_a_attach_in, lane_b_attach_in;
   logic [2:0] phy_clk_en, phy_a_en, phy_b_en;
   logic [1:0] cfg_mode;
   wire [10:0] outs = {cfg_mode, phy_clk_en, phy_a_en, phy_b_en};
   logic [31:0] r = 32'hdc5f;
   int failures = 0, n_compared = 0;
   always #50 core_clk = ~core_clk;
   tcap_pc_model pc (.*);
   tcap_attach_ctrl dut (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [10:0] want(input logic e, m, input logic [2:0] t, o, x);
      logic [2:0] g;
      g = m ? t & ~x : t;
      return e ? {2'h0, t, t, 3'h0} : {m, !m, g, g & ~o, g & o};
   endfunction
   task automatic chk(input logic [10:0] got, w);
      n_compared++;
      if (got !== w)
      begin
         failures++;
         $display("Error at %0t: got %h, expected %h", $time, got, w);
      end
   endtask
   task automatic report_and_stop;
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      {ext_mux_select, mux_mode_select, attach_polarity_select, att, ori, bad} = '0;
      repeat (2) @(negedge core_clk);
      chk(outs, 11'h200);
      $display("reset test done");
      rst = 0;
      for (int i = 0; i < 80; i++)
      begin
         r = lfsr(r);
         {ext_mux_select, mux_mode_select, attach_polarity_select, att, ori} = r[8:0];
         bad = r[13:11] & r[16:14];
         // Both lanes active in mode 2, then inverted idle pins
         if (i < 2)
            {ext_mux_select, mux_mode_select, attach_polarity_select, att, bad} = i ? 9'h100 : 9'h0bf;
         repeat (4) @(negedge core_clk);
         chk(outs, want(ext_mux_select, mux_mode_select, att, ori, bad));
      end
      $display("random test done");
      report_and_stop;
   end
   initial
   begin
      #100000;
      failures++;
      report_and_stop;
   end
endmodule // tcap_attach_ctrl_tb
`default_nettype wire

// >>> verif/tcap_pc_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcap_pc_model
(
   // Commands
   input wire logic attach_polarity_select,
   input wire logic [2:0] att,
   input wire logic [2:0] ori,
   input wire logic [2:0] bad,
   // Pins
   output logic [2:0] attach_in,
   output logic [2:0] plug_orientation_in,
   output logic [2:0] lane_a_attach_in,
   output logic [2:0] lane_b_attach_in
);
   wire [2:0] iv = {3{~attach_polarity_select}};
   assign attach_in = att ^ iv;
   assign plug_orientation_in = ori ^ iv;
   assign lane_a_attach_in = (att & ~ori | bad) ^ iv;
   assign lane_b_attach_in = (att & ori | bad) ^ iv;
endmodule // tcap_pc_model
`default_nettype wire

// >>> verilog/tcap_attach_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "tcap_map.vh"

module tcap_attach_ctrl
#(
   parameter NUM_PORTS = `TCAP_NUM_PORTS
)
(
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Static straps
   input wire ext_mux_select,
   input wire mux_mode_select,
   input wire attach_polarity_select,
   // Type-C controller indications
   input wire [NUM_PORTS-1:0] attach_in,
   input wire [NUM_PORTS-1:0] plug_orientation_in,
   input wire [NUM_PORTS-1:0] lane_a_attach_in,
   input wire [NUM_PORTS-1:0] lane_b_attach_in,
   // PHY controls
   output reg [NUM_PORTS-1:0] phy_clk_en,
   output reg [NUM_PORTS-1:0] phy_a_en,
   output reg [NUM_PORTS-1:0] phy_b_en,
   output reg [1:0] cfg_mode
);

// ****************************************
// Strap synchronisers
// ****************************************
// Straps share the input latency,
// so mode and inputs stay aligned
wire [NUM_PORTS-1:0] s_attach;
wire [NUM_PORTS-1:0] s_orient;
wire [NUM_PORTS-1:0] s_lane_a;
wire [NUM_PORTS-1:0] s_lane_b;
wire s_ext;
wire s_mode;
wire s_pol;

tcap_sync u_sync_ext
(
   .core_clk(core_clk),
   .rst(rst),
   .din(ext_mux_select),
   .dout(s_ext)
);

tcap_sync u_sync_mode
(
   .core_clk(core_clk),
   .rst(rst),
   .din(mux_mode_select),
   .dout(s_mode)
);

tcap_sync u_sync_pol
(
   .core_clk(core_clk),
   .rst(rst),
   .din(attach_polarity_select),
   .dout(s_pol)
);

// ****************************************
// Attach input synchronisers
// ****************************************
genvar gi;
generate
   for (gi = 0; gi < NUM_PORTS; gi = gi + 1)
   begin : g_sync
      tcap_sync u_att
      (
         .core_clk(core_clk),
         .rst(rst),
         .din(attach_in[gi]),
         .dout(s_attach[gi])
      );
      tcap_sync u_ori
      (
         .core_clk(core_clk),
         .rst(rst),
         .din(plug_orientation_in[gi]),
         .dout(s_orient[gi])
      );
      tcap_sync u_la
      (
         .core_clk(core_clk),
         .rst(rst),
         .din(lane_a_attach_in[gi]),
         .dout(s_lane_a[gi])
      );
      tcap_sync u_lb
      (
         .core_clk(core_clk),
         .rst(rst),
         .din(lane_b_attach_in[gi]),
         .dout(s_lane_b[gi])
      );
   end
endgenerate

// ****************************************
// Polarity and mode decode
// ****************************************
// Low polarity strap means inputs are active low
wire [NUM_PORTS-1:0] pol_mask = {NUM_PORTS{~s_pol}};
wire [NUM_PORTS-1:0] att = s_attach ^ pol_mask;
wire [NUM_PORTS-1:0] ori = s_orient ^ pol_mask;
wire [NUM_PORTS-1:0] la = s_lane_a ^ pol_mask;
wire [NUM_PORTS-1:0] lb = s_lane_b ^ pol_mask;

reg [1:0] next_cfg_mode;
reg [NUM_PORTS-1:0] next_clk_en;
reg [NUM_PORTS-1:0] next_a_en;
reg [NUM_PORTS-1:0] next_b_en;

always @*
begin
   // External mux strap overrides mode select
   if (s_ext)
      next_cfg_mode = `TCAP_CFG_EXT_MUX;
   else if (s_mode)
      next_cfg_mode = `TCAP_CFG_MODE2;
   else
      next_cfg_mode = `TCAP_CFG_MODE1;
end

// ****************************************
// External mux candidates
// ****************************************
// Attach gates clock, lane steering outside
wire [NUM_PORTS-1:0] ext_clk_en = att;
wire [NUM_PORTS-1:0] ext_a_en = att;
wire [NUM_PORTS-1:0] ext_b_en = {NUM_PORTS{`TCAP_PHY_OFF}};

// ****************************************
// Mode 1 candidates
// ****************************************
// Active orientation input means B side
wire [NUM_PORTS-1:0] m1_clk_en = att;
wire [NUM_PORTS-1:0] m1_a_en = att & ~ori;
wire [NUM_PORTS-1:0] m1_b_en = att & ori;

// ****************************************
// Mode 2 candidates
// ****************************************
// Both sides active is ambiguous, keep both off
wire [NUM_PORTS-1:0] m2_a_en = la & ~lb;
wire [NUM_PORTS-1:0] m2_b_en = lb & ~la;
wire [NUM_PORTS-1:0] m2_clk_en = m2_a_en | m2_b_en;

// ****************************************
// PHY enable selection
// ****************************************
always @*
begin
   case (next_cfg_mode)
      `TCAP_CFG_EXT_MUX:
      begin
         next_clk_en = ext_clk_en;
         next_a_en = ext_a_en;
         next_b_en = ext_b_en;
      end
      `TCAP_CFG_MODE1:
      begin
         next_clk_en = m1_clk_en;
         next_a_en = m1_a_en;
         next_b_en = m1_b_en;
      end
      `TCAP_CFG_MODE2:
      begin
         next_a_en = m2_a_en;
         next_b_en = m2_b_en;
         next_clk_en = m2_clk_en;
      end
      default:
      begin
         // Unused code, all PHYs off
         next_clk_en = {NUM_PORTS{`TCAP_PHY_OFF}};
         next_a_en = {NUM_PORTS{`TCAP_PHY_OFF}};
         next_b_en = {NUM_PORTS{`TCAP_PHY_OFF}};
      end
   endcase
end

// ****************************************
// Output registers
// ****************************************
// PHY controls come straight from flops
always @(posedge core_clk)
begin
   if (rst)
   begin
      // All PHYs off, mode 1 as with strap floating
      phy_clk_en <= {NUM_PORTS{`TCAP_PHY_OFF}};
      phy_a_en <= {NUM_PORTS{`TCAP_PHY_OFF}};
      phy_b_en <= {NUM_PORTS{`TCAP_PHY_OFF}};
      cfg_mode <= `TCAP_CFG_MODE1;
   end
   else
   begin
      // Detach drops enables on the third edge, after the two synchroniser stages
      phy_clk_en <= next_clk_en;
      phy_a_en <= next_a_en;
      phy_b_en <= next_b_en;
      cfg_mode <= next_cfg_mode;
   end
end

endmodule // tcap_attach_ctrl

`default_nettype wire

// >>> verilog/tcap_map.vh
`ifndef TCAP_MAP_VH
`define TCAP_MAP_VH

// Receptacle configurations
`define TCAP_CFG_EXT_MUX 2'b00
`define TCAP_CFG_MODE1 2'b01
`define TCAP_CFG_MODE2 2'b10

// Port count and synchroniser depth
`define TCAP_NUM_PORTS 3
`define TCAP_SYNC_STAGES 2

// Reset values
`define TCAP_PHY_OFF 1'b0

`endif

// >>> verilog/tcap_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for one level input
module tcap_sync
(
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Level in and out
   input wire din,
   output reg dout
);

reg meta;

always @(posedge core_clk)
begin
   if (rst)
   begin
      meta <= 1'b0;
      dout <= 1'b0;
   end
   else
   begin
      meta <= din;
      dout <= meta;
   end
end

endmodule // tcap_sync

`default_nettype wire
